//--- verilog/cmpc_map.vh
/*
 Holds the opcodes, register offsets, parameter encodings and timing
 counts of the chirp modem configuration block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef CMPC_MAP_VH
`define CMPC_MAP_VH

// ****************************************
// Command opcodes
// ****************************************
`define CMPC_OP_STANDBY 8'h80
`define CMPC_OP_PKT_KIND 8'h8a
`define CMPC_OP_FREQ 8'h86
`define CMPC_OP_BUF_BASE 8'h8f
`define CMPC_OP_MOD_CFG 8'h8b
`define CMPC_OP_PKT_FMT 8'h8c
`define CMPC_OP_REG_WRITE 8'h18
`define CMPC_OP_REG_READ 8'h19
`define CMPC_OP_IRQ_CLEAR 8'h97
`define CMPC_OP_BUF_QUERY 8'h17
`define CMPC_OP_BUF_READ 8'h1b
`define CMPC_OP_SYNC_STAT 8'h1d

// ****************************************
// Register offsets
// ****************************************
`define CMPC_REG_SF_TUNING 16'h0925
`define CMPC_REG_FREQ_COMP 16'h093c
`define CMPC_REG_SYNC_HI 16'h0944
`define CMPC_REG_SYNC_LO 16'h0945

// ****************************************
// Parameter encodings
// ****************************************
`define CMPC_SF_MIN 8'h50
`define CMPC_SF_MAX 8'hc0
`define CMPC_BW_1625 8'h0a
`define CMPC_BW_812 8'h18
`define CMPC_BW_406 8'h26
`define CMPC_BW_203 8'h34
`define CMPC_CR_MAX_LEGACY 8'h04
`define CMPC_CR_MAX_LONG 8'h07
`define CMPC_HDR_EXPLICIT 8'h00
`define CMPC_HDR_IMPLICIT 8'h80
`define CMPC_CRC_ON 8'h20
`define CMPC_CRC_OFF 8'h00
`define CMPC_IQ_SWAPPED 8'h00
`define CMPC_IQ_NORMAL 8'h40
`define CMPC_CHIRP_KIND 8'h01
`define CMPC_SYNC_ERROR 3'h0
`define CMPC_SYNC_ADDR1 3'h1
`define CMPC_SYNC_ADDR2 3'h2
`define CMPC_SYNC_ADDR3 3'h4

// ****************************************
// Timing
// ****************************************
`define CMPC_CLK_MHZ 200
`define CMPC_CAL_TIME_US 100
`define CMPC_CAL_CYCLES (`CMPC_CAL_TIME_US * `CMPC_CLK_MHZ)

`endif

//--- verilog/cmpc_modem_cfg.v
/*
 Command interpreter for the chirp modem configuration, packet format,
 sync word registers and the receive completion status.
 Assumes a host that presents one whole command per cmd_valid pulse and
 a receive datapath on the same clock that reports its events.
*/
`timescale 1ns/1ps
// Overview of operation
// - Sync match code: 000 error, 001/010/100 addresses one to three.
// - Interrupt clear drops only flags whose mask bit is one.
// - Each DIO is the OR of its mapped flags, low once cleared.
// - Buffer query returns last packet length and its start offset.
// - After reset calibrate, then enter RC standby with busy low.
// - Frequency word LSB is 52e6/2^18 Hz, sets transmit carrier.
// - Transmit and receive base offsets steer packet handler memory.
// - Spreading factor 0x50..0xc0 in steps 0x10 selects 5..12.
// - Bandwidth codes 0x0a, 0x18, 0x26, 0x34 decode to four widths.
// - Rates 1..4 legacy interleave; 5..7 long interleave variants.
// - Long interleave works with implicit header, scrambling kept.
// - Preamble symbols are mantissa times two to the exponent.
// - Header mode 0x00 explicit, 0x80 implicit fixed length.
// - Payload length parameter accepted from 1 to 255.
// - CRC code 0x20 enables, 0x00 disables.
// - IQ code 0x00 swapped, 0x40 normal.
`include "cmpc_map.vh"
module cmpc_modem_cfg #(
  parameter CAL_CYCLES = `CMPC_CAL_CYCLES,
  parameter IRQ_W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [7:0] cmd_op,
  input wire [7:0] cmd_arg0,
  input wire [7:0] cmd_arg1,
  input wire [7:0] cmd_arg2,
  input wire [7:0] cmd_arg3,
  input wire [7:0] cmd_arg4,
  input wire [15:0] irq_set,
  input wire [15:0] dio1_map,
  input wire [15:0] dio2_map,
  input wire [15:0] dio3_map,
  input wire rx_done,
  input wire [7:0] rx_len,
  input wire [2:0] rx_sync_hit,
  output reg busy,
  output reg rc_oscillator_standby,
  output reg cmd_error,
  output reg rsp_valid,
  output reg [15:0] rsp_data,
  output reg [7:0] buf_rd_offset,
  output reg [7:0] buf_rd_count,
  output reg buf_rd_start,
  output reg [15:0] irq_status,
  output wire dio1,
  output wire dio2,
  output wire dio3,
  output reg chirp_packet_kind,
  output reg [23:0] carrier_freq_word,
  output reg [7:0] transmit_base_offset,
  output reg [7:0] receive_base_offset,
  output reg [3:0] spread_factor,
  output reg [1:0] bandwidth_sel,
  output reg [2:0] coding_rate,
  output reg long_interleave,
  output reg [19:0] preamble_symbols,
  output reg implicit_header,
  output reg [7:0] payload_length,
  output reg checksum_on,
  output reg iq_swapped,
  output reg [7:0] sf_dependent_tuning,
  output reg [7:0] freq_error_comp_mode,
  output reg [7:0] sync_word_high_nibble,
  output reg [7:0] sync_word_low_nibble
);

  // ****************************************
  // Reset release and state
  // ****************************************
  localparam ST_CAL = 2'b00;
  localparam ST_STANDBY = 2'b01;
  localparam ST_ACTIVE = 2'b10;

  reg [1:0] rst_sync;
  wire rst_i_n;
  reg [1:0] state;
  reg [31:0] cal_cnt;
  reg [7:0] received_length;
  reg [7:0] received_start_offset;
  reg [2:0] sync_match_code;
  reg [15:0] next_irq;

  assign rst_i_n = rst_sync[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // Preamble length, mantissa times two to the exponent
  function [19:0] pbl_len;
    input [7:0] p;
    begin
      pbl_len = {16'h0000, p[3:0]} << p[7:4];
    end
  endfunction

  // Recognised register offset
  function reg_known;
    input [15:0] a;
    begin
      reg_known = (a == `CMPC_REG_SF_TUNING) ||
        (a == `CMPC_REG_FREQ_COMP) || (a == `CMPC_REG_SYNC_HI) ||
        (a == `CMPC_REG_SYNC_LO);
    end
  endfunction

  wire [15:0] reg_addr = {cmd_arg0, cmd_arg1};
  wire cmd_take = cmd_valid && (state != ST_CAL);
  wire cfg_ok = (state == ST_STANDBY);
  wire sf_ok = (cmd_arg0 >= `CMPC_SF_MIN) &&
    (cmd_arg0 <= `CMPC_SF_MAX) && (cmd_arg0[3:0] == 4'h0);
  wire bw_ok = (cmd_arg1 == `CMPC_BW_1625) ||
    (cmd_arg1 == `CMPC_BW_812) || (cmd_arg1 == `CMPC_BW_406) ||
    (cmd_arg1 == `CMPC_BW_203);
  wire cr_ok = (cmd_arg2 != 8'h00) && (cmd_arg2 <= `CMPC_CR_MAX_LONG);
  wire pbl_ok = (cmd_arg0[3:0] != 4'h0) && (cmd_arg0[7:4] != 4'h0);
  wire hdr_ok = (cmd_arg1 == `CMPC_HDR_EXPLICIT) ||
    (cmd_arg1 == `CMPC_HDR_IMPLICIT);
  wire len_ok = (cmd_arg2 != 8'h00);
  wire crc_ok = (cmd_arg3 == `CMPC_CRC_ON) || (cmd_arg3 == `CMPC_CRC_OFF);
  wire iq_ok = (cmd_arg4 == `CMPC_IQ_SWAPPED) ||
    (cmd_arg4 == `CMPC_IQ_NORMAL);

  // ****************************************
  // Interrupt flags and DIO lines
  // ****************************************
  always @* begin
    next_irq = irq_status;
    if (cmd_take && cmd_op == `CMPC_OP_IRQ_CLEAR)
      next_irq = irq_status & ~{cmd_arg0, cmd_arg1};
    next_irq = next_irq | irq_set;
  end

  assign dio1 = |(irq_status & dio1_map);
  assign dio2 = |(irq_status & dio2_map);
  assign dio3 = |(irq_status & dio3_map);

  // ****************************************
  // Calibration and standby sequencing
  // ****************************************
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state <= ST_CAL;
      cal_cnt <= 32'h00000000;
      busy <= 1'b1;
      rc_oscillator_standby <= 1'b0;
    end else begin
      case (state)
        ST_CAL: begin
          if (cal_cnt >= CAL_CYCLES - 1) begin
            state <= ST_STANDBY;
            busy <= 1'b0;
            rc_oscillator_standby <= 1'b1;
          end else begin
            cal_cnt <= cal_cnt + 32'h00000001;
          end
        end
        ST_STANDBY: begin
          if (cmd_take && cmd_op == `CMPC_OP_BUF_READ) begin
            state <= ST_ACTIVE;
            rc_oscillator_standby <= 1'b0;
          end
        end
        ST_ACTIVE: begin
          if (cmd_take && cmd_op == `CMPC_OP_STANDBY) begin
            state <= ST_STANDBY;
            rc_oscillator_standby <= 1'b1;
          end
        end
        default: begin
          state <= ST_CAL;
        end
      endcase
    end
  end

  // ****************************************
  // Command decoding
  // ****************************************
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cmd_error <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      buf_rd_offset <= 8'h00;
      buf_rd_count <= 8'h00;
      buf_rd_start <= 1'b0;
      irq_status <= 16'h0000;
      chirp_packet_kind <= 1'b0;
      carrier_freq_word <= 24'h000000;
      transmit_base_offset <= 8'h00;
      receive_base_offset <= 8'h00;
      spread_factor <= 4'h5;
      bandwidth_sel <= 2'h0;
      coding_rate <= 3'h1;
      long_interleave <= 1'b0;
      preamble_symbols <= 20'h0000c;
      implicit_header <= 1'b0;
      payload_length <= 8'h01;
      checksum_on <= 1'b0;
      iq_swapped <= 1'b0;
      sf_dependent_tuning <= 8'h00;
      freq_error_comp_mode <= 8'h00;
      sync_word_high_nibble <= 8'h00;
      sync_word_low_nibble <= 8'h00;
      received_length <= 8'h00;
      received_start_offset <= 8'h00;
      sync_match_code <= `CMPC_SYNC_ERROR;
    end else begin
      cmd_error <= 1'b0;
      rsp_valid <= 1'b0;
      buf_rd_start <= 1'b0;
      irq_status <= next_irq;
      if (rx_done) begin
        received_length <= rx_len;
        received_start_offset <= receive_base_offset;
        case (rx_sync_hit)
          3'b001: sync_match_code <= `CMPC_SYNC_ADDR1;
          3'b010: sync_match_code <= `CMPC_SYNC_ADDR2;
          3'b100: sync_match_code <= `CMPC_SYNC_ADDR3;
          default: sync_match_code <= `CMPC_SYNC_ERROR;
        endcase
      end
      if (cmd_take) begin
        case (cmd_op)
          `CMPC_OP_STANDBY: begin
          end
          `CMPC_OP_PKT_KIND: begin
            if (cfg_ok)
              chirp_packet_kind <= (cmd_arg0 == `CMPC_CHIRP_KIND);
            else
              cmd_error <= 1'b1;
          end
          `CMPC_OP_FREQ: begin
            if (cfg_ok)
              carrier_freq_word <= {cmd_arg0, cmd_arg1, cmd_arg2};
            else
              cmd_error <= 1'b1;
          end
          `CMPC_OP_BUF_BASE: begin
            if (cfg_ok) begin
              transmit_base_offset <= cmd_arg0;
              receive_base_offset <= cmd_arg1;
            end else begin
              cmd_error <= 1'b1;
            end
          end
          `CMPC_OP_MOD_CFG: begin
            if (cfg_ok && sf_ok && bw_ok && cr_ok) begin
              spread_factor <= cmd_arg0[7:4];
              case (cmd_arg1)
                `CMPC_BW_1625: bandwidth_sel <= 2'h0;
                `CMPC_BW_812: bandwidth_sel <= 2'h1;
                `CMPC_BW_406: bandwidth_sel <= 2'h2;
                default: bandwidth_sel <= 2'h3;
              endcase
              long_interleave <= (cmd_arg2 > `CMPC_CR_MAX_LEGACY);
              if (cmd_arg2 == `CMPC_CR_MAX_LONG)
                coding_rate <= 3'h4;
              else if (cmd_arg2 > `CMPC_CR_MAX_LEGACY)
                coding_rate <= cmd_arg2[2:0] - 3'h4;
              else
                coding_rate <= cmd_arg2[2:0];
            end else begin
              cmd_error <= 1'b1;
            end
          end
          `CMPC_OP_PKT_FMT: begin
            if (cfg_ok && pbl_ok && hdr_ok && len_ok && crc_ok && iq_ok)
            begin
              preamble_symbols <= pbl_len(cmd_arg0);
              implicit_header <= (cmd_arg1 == `CMPC_HDR_IMPLICIT);
              payload_length <= cmd_arg2;
              checksum_on <= (cmd_arg3 == `CMPC_CRC_ON);
              iq_swapped <= (cmd_arg4 == `CMPC_IQ_SWAPPED);
            end else begin
              cmd_error <= 1'b1;
            end
          end
          `CMPC_OP_REG_WRITE: begin
            case (reg_addr)
              `CMPC_REG_SF_TUNING: sf_dependent_tuning <= cmd_arg2;
              `CMPC_REG_FREQ_COMP: freq_error_comp_mode <= cmd_arg2;
              `CMPC_REG_SYNC_HI: sync_word_high_nibble <= cmd_arg2;
              `CMPC_REG_SYNC_LO: sync_word_low_nibble <= cmd_arg2;
              default: cmd_error <= 1'b1;
            endcase
          end
          `CMPC_OP_REG_READ: begin
            rsp_valid <= 1'b1;
            cmd_error <= !reg_known(reg_addr);
            case (reg_addr)
              `CMPC_REG_SF_TUNING: rsp_data <= {8'h00, sf_dependent_tuning};
              `CMPC_REG_FREQ_COMP: rsp_data <= {8'h00, freq_error_comp_mode};
              `CMPC_REG_SYNC_HI: rsp_data <= {8'h00, sync_word_high_nibble};
              `CMPC_REG_SYNC_LO: rsp_data <= {8'h00, sync_word_low_nibble};
              default: rsp_data <= 16'h0000;
            endcase
          end
          `CMPC_OP_IRQ_CLEAR: begin
          end
          `CMPC_OP_BUF_QUERY: begin
            rsp_valid <= 1'b1;
            rsp_data <= {received_length, received_start_offset};
          end
          `CMPC_OP_SYNC_STAT: begin
            rsp_valid <= 1'b1;
            rsp_data <= {13'h0000, sync_match_code};
          end
          `CMPC_OP_BUF_READ: begin
            buf_rd_offset <= cmd_arg0;
            buf_rd_count <= cmd_arg1;
            buf_rd_start <= 1'b1;
          end
          default: begin
            cmd_error <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // cmpc_modem_cfg

//--- dv/cmpc_modem_cfg_sva.sv
/*
 Concurrent checks on the ports of the chirp modem configuration block.
 Assumes binding to cmpc_modem_cfg and the opcodes of cmpc_map.vh.
*/
`timescale 1ns/1ps
`include "cmpc_map.vh"
module cmpc_modem_cfg_sva #(
  parameter CAL_CYCLES = 4
) (
  input wire clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [7:0] cmd_op,
  input wire [7:0] cmd_arg0,
  input wire [7:0] cmd_arg1,
  input wire [15:0] irq_set,
  input wire [15:0] dio1_map,
  input wire rx_done,
  input wire [7:0] rx_len,
  input wire [2:0] rx_sync_hit,
  input wire busy,
  input wire rc_oscillator_standby,
  input wire cmd_error,
  input wire rsp_valid,
  input wire [15:0] rsp_data,
  input wire [15:0] irq_status,
  input wire dio1,
  input wire [7:0] transmit_base_offset,
  input wire [7:0] receive_base_offset
);
  reg [15:0] cyc;
  wire taken = cmd_valid & ~busy;

  // Cycles since reset release, saturating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cyc <= 16'h0000;
    else if (cyc != 16'hffff)
      cyc <= cyc + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_after_rx(op);
    rx_done ##2 (taken && cmd_op == op);
  endsequence

  a_sync_code: assert property (
    s_after_rx(`CMPC_OP_SYNC_STAT) |=> rsp_valid && rsp_data == {13'h0000,
      ($onehot($past(rx_sync_hit, 3)) ? $past(rx_sync_hit, 3) : 3'h0)})
    else $error("sync code mismatch");
  a_irq_clear: assert property (
    taken && cmd_op == `CMPC_OP_IRQ_CLEAR |=> irq_status ==
      (($past(irq_status) & ~{$past(cmd_arg0), $past(cmd_arg1)})
      | $past(irq_set)))
    else $error("interrupt clear mismatch");
  a_dio_or: assert property (
    dio1 == |(irq_status & dio1_map))
    else $error("dio not the or of its flags");
  a_buf_query: assert property (
    s_after_rx(`CMPC_OP_BUF_QUERY) |=> rsp_valid &&
      rsp_data == {$past(rx_len, 3), $past(receive_base_offset, 3)})
    else $error("buffer query mismatch");
  a_busy_cal: assert property (
    cyc < CAL_CYCLES |-> busy)
    else $error("busy dropped during calibration");
  a_cal_done: assert property (
    cyc > CAL_CYCLES + 3 |-> !busy)
    else $error("busy stuck after calibration");
  a_standby_entry: assert property (
    $fell(busy) |-> rc_oscillator_standby)
    else $error("not in standby when busy fell");
  a_busy_silent: assert property (
    busy && cmd_valid |=> !rsp_valid && !cmd_error)
    else $error("command answered while busy");
  a_base_set: assert property (
    taken && rc_oscillator_standby && cmd_op == `CMPC_OP_BUF_BASE |=>
      {transmit_base_offset, receive_base_offset} ==
      {$past(cmd_arg0), $past(cmd_arg1)})
    else $error("base offsets mismatch");
  a_bad_bw: assert property (
    taken && cmd_op == `CMPC_OP_MOD_CFG &&
      !(cmd_arg1 inside {8'h0a, 8'h18, 8'h26, 8'h34}) |=> cmd_error)
    else $error("illegal bandwidth accepted");
endmodule // cmpc_modem_cfg_sva

bind cmpc_modem_cfg cmpc_modem_cfg_sva #(.CAL_CYCLES(CAL_CYCLES)) i_sva (.*);

//--- dv/cmpc_host_model.sv
/*
 Host model that issues commands to the modem configuration block.
 Assumes the bench calls its tasks and judges the answers.
*/
`timescale 1ns/1ps
`include "cmpc_map.vh"
module cmpc_host_model (
  input wire clk,
  input wire [15:0] rsp_data,
  output reg cmd_valid,
  output reg [7:0] cmd_op,
  output reg [7:0] cmd_arg0,
  output reg [7:0] cmd_arg1,
  output reg [7:0] cmd_arg2,
  output reg [7:0] cmd_arg3,
  output reg [7:0] cmd_arg4
);
  localparam [7:0] nil = 8'h00;

  initial begin
    {cmd_valid, cmd_op, cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3} = 41'h0;
    cmd_arg4 = nil;
  end

  task send(input [7:0] op, a0, a1, a2, a3, a4);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      {cmd_op, cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4} <=
        {op, a0, a1, a2, a3, a4};
      @(posedge clk);
      cmd_valid <= 1'b0;
      // Released lines do not keep the last command
      {cmd_op, cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4} <=
        ~{op, a0, a1, a2, a3, a4};
      #1;
    end
  endtask

  task setup(input [7:0] sf, bw, cr);
    reg [7:0] tune;
    begin
      send(`CMPC_OP_STANDBY, nil, nil, nil, nil, nil);
      send(`CMPC_OP_PKT_KIND, `CMPC_CHIRP_KIND, nil, nil, nil, nil);
      send(`CMPC_OP_MOD_CFG, sf, bw, cr, nil, nil);
      tune = sf < 8'h70 ? 8'h1e : sf < 8'h90 ? 8'h37 : 8'h32;
      send(`CMPC_OP_REG_WRITE, 8'h09, 8'h25, tune, nil, nil);
      send(`CMPC_OP_REG_WRITE, 8'h09, 8'h3c, 8'h01, nil, nil);
    end
  endtask

  task sync_word(input [7:0] w);
    begin
      send(`CMPC_OP_REG_READ, 8'h09, 8'h44, nil, nil, nil);
      send(`CMPC_OP_REG_WRITE, 8'h09, 8'h44, {w[7:4], rsp_data[3:0]}, nil,
        nil);
      send(`CMPC_OP_REG_READ, 8'h09, 8'h45, nil, nil, nil);
      send(`CMPC_OP_REG_WRITE, 8'h09, 8'h45, {w[3:0], rsp_data[3:0]}, nil,
        nil);
    end
  endtask
endmodule // cmpc_host_model

//--- dv/cmpc_modem_cfg_test.sv
/*
 Self-checking bench of the chirp modem configuration block.
 Assumes the host model drives commands and the bench drives events.
*/
`timescale 1ns/1ps
`include "cmpc_map.vh"
module cmpc_modem_cfg_test;
  localparam [7:0] nil = 8'h00;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg rx_done = 1'b0;
  reg [7:0] rx_len = 8'h00;
  reg [2:0] rx_sync_hit = 3'h0;
  reg [15:0] irq_set = 16'h0000;
  reg [15:0] dio1_map = 16'h0003;
  reg [15:0] dio2_map = 16'h0100;
  reg [15:0] dio3_map = 16'h00f0;
  wire cmd_valid, busy, rc_oscillator_standby, cmd_error, rsp_valid;
  wire buf_rd_start, dio1, dio2, dio3, chirp_packet_kind, long_interleave;
  wire implicit_header, checksum_on, iq_swapped;
  wire [7:0] cmd_op, cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4;
  wire [7:0] buf_rd_offset, buf_rd_count, transmit_base_offset;
  wire [7:0] receive_base_offset, payload_length, sf_dependent_tuning;
  wire [7:0] freq_error_comp_mode, sync_word_high_nibble;
  wire [7:0] sync_word_low_nibble;
  wire [15:0] rsp_data, irq_status;
  wire [23:0] carrier_freq_word;
  wire [3:0] spread_factor;
  wire [1:0] bandwidth_sel;
  wire [2:0] coding_rate;
  wire [19:0] preamble_symbols;
  wire [31:0] bw_codes = {8'h34, 8'h26, 8'h18, 8'h0a};
  integer bad_count = 0;
  integer comparisons = 0;

  always #2.5 clk = ~clk;

  cmpc_modem_cfg #(.CAL_CYCLES(4)) i_dut (.*);
  cmpc_host_model i_host (.*);

  task chk(input [24:0] seen, exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task summarize;
    begin
      if (bad_count == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_calibrate;
    integer n;
    begin
      chk(busy, 1'b1);
      i_host.send(`CMPC_OP_BUF_QUERY, nil, nil, nil, nil, nil);
      chk({rsp_valid, cmd_error}, 2'b00);
      for (n = 0; busy !== 1'b0; n = n + 1) begin
        if (n == 50) begin
          bad_count = bad_count + 1;
          summarize;
        end
        @(posedge clk);
      end
      #1;
      chk(rc_oscillator_standby, 1'b1);
    end
  endtask

  task t_modem;
    integer i;
    reg [7:0] cr;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        cr = i % 7 + 1;
        i_host.setup(8'h50 + 8'h10 * i, bw_codes[8 * (i % 4) +: 8], cr);
        chk(spread_factor, i + 5);
        chk(bandwidth_sel, i % 4);
        chk(coding_rate, cr == 7 ? 4 : cr > 4 ? cr - 4 : cr);
        chk(long_interleave, cr > 4);
        chk(sf_dependent_tuning, i < 2 ? 8'h1e : i < 4 ? 8'h37 : 8'h32);
        chk(freq_error_comp_mode, 8'h01);
      end
    end
  endtask

  task t_format;
    begin
      i_host.setup(8'h70, 8'h0a, 8'h07);
      i_host.send(`CMPC_OP_FREQ, 8'h12, 8'h34, 8'h56, nil, nil);
      chk(carrier_freq_word, 24'h123456);
      i_host.send(`CMPC_OP_BUF_BASE, 8'h10, 8'h80, nil, nil, nil);
      chk({transmit_base_offset, receive_base_offset}, 16'h1080);
      // Long 4/8 with checksum keeps the payload at 253
      i_host.send(`CMPC_OP_PKT_FMT, 8'h31, 8'h80, 8'hfd, 8'h20, 8'h00);
      chk(cmd_error, 1'b0);
      chk({implicit_header, checksum_on, iq_swapped, payload_length},
        11'h7fd);
      chk(preamble_symbols, 20'h00008);
      i_host.send(`CMPC_OP_PKT_FMT, 8'hff, 8'h00, 8'hff, 8'h00, 8'h40);
      chk({implicit_header, checksum_on, iq_swapped, payload_length},
        11'h0ff);
      chk(preamble_symbols, 20'h78000);
    end
  endtask

  task t_refuse;
    begin
      i_host.send(`CMPC_OP_MOD_CFG, 8'h90, 8'h11, 8'h01, nil, nil);
      chk({cmd_error, spread_factor}, 5'h17);
      i_host.send(`CMPC_OP_MOD_CFG, 8'h55, 8'h0a, 8'h01, nil, nil);
      chk({cmd_error, spread_factor}, 5'h17);
      i_host.send(`CMPC_OP_REG_WRITE, 8'h09, 8'h99, 8'h5a, nil, nil);
      chk(cmd_error, 1'b1);
    end
  endtask

  task t_irq;
    begin
      irq_set <= 16'h00ff;
      @(posedge clk);
      irq_set <= 16'h0000;
      @(posedge clk);
      #1;
      chk({irq_status, dio1, dio2, dio3}, {16'h00ff, 3'b101});
      i_host.send(`CMPC_OP_IRQ_CLEAR, 8'h00, 8'h01, nil, nil, nil);
      chk({irq_status, dio1, dio2, dio3}, {16'h00fe, 3'b101});
      i_host.send(`CMPC_OP_IRQ_CLEAR, 8'h00, 8'hf2, nil, nil, nil);
      chk({irq_status, dio1, dio2, dio3}, {16'h000c, 3'b000});
    end
  endtask

  task rx_pulse(input [2:0] hit, input [7:0] len);
    begin
      @(posedge clk);
      rx_done <= 1'b1;
      rx_sync_hit <= hit;
      rx_len <= len;
      @(posedge clk);
      rx_done <= 1'b0;
    end
  endtask

  task t_rx;
    integer k;
    reg [7:0] len;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        len = 8'h20 + k;
        rx_pulse(12'h711 >> (3 * k), len);
        i_host.send(`CMPC_OP_SYNC_STAT, nil, nil, nil, nil, nil);
        chk({rsp_valid, rsp_data}, {1'b1, 13'h0, 3'(12'h111 >> (3 * k))});
        rx_pulse(3'h1, len);
        i_host.send(`CMPC_OP_BUF_QUERY, nil, nil, nil, nil, nil);
        chk({rsp_valid, rsp_data}, {1'b1, len, 8'h80});
        i_host.send(`CMPC_OP_BUF_READ, rsp_data[7:0], rsp_data[15:8], nil,
          nil, nil);
        chk({buf_rd_start, buf_rd_offset, buf_rd_count}, {1'b1, 8'h80, len});
        i_host.send(`CMPC_OP_FREQ, 8'h01, 8'h02, 8'h03, nil, nil);
        chk({cmd_error, carrier_freq_word}, {1'b1, 24'h123456});
        i_host.send(`CMPC_OP_STANDBY, nil, nil, nil, nil, nil);
      end
    end
  endtask

  task t_sync;
    begin
      i_host.send(`CMPC_OP_REG_WRITE, 8'h09, 8'h44, 8'h0a, nil, nil);
      i_host.send(`CMPC_OP_REG_WRITE, 8'h09, 8'h45, 8'h05, nil, nil);
      i_host.sync_word(8'hc3);
      chk({sync_word_high_nibble, sync_word_low_nibble}, 16'hca35);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_calibrate;
    t_modem;
    t_format;
    t_refuse;
    t_irq;
    t_rx;
    t_sync;
    summarize;
  end
endmodule // cmpc_modem_cfg_test
